// >>> rtl/ttls_map.svh
`ifndef TTLS_MAP_SVH
`define TTLS_MAP_SVH
// Register byte offsets
`define TTLS_REG_CTRL 8'h00
`define TTLS_REG_STATUS 8'h04
// Control register fields and reset value
`define TTLS_CTRL_LONG_BOT 0
`define TTLS_CTRL_RESET 1'h1
// Status register fields
`define TTLS_ST_STATE 3:0
`define TTLS_ST_LOAD_CHECK 4
`define TTLS_ST_READY 5
`define TTLS_ST_ATTEMPT2 6
`define TTLS_ST_TAPE_SEEN 7
`define TTLS_ST_GAP 13:8
// Gap counts at which the sequence is checked
`define TTLS_CNT_THREAD_OFF 6'h02
`define TTLS_CNT_TAPE 6'h07
`define TTLS_CNT_REELS1 6'h0c
`define TTLS_CNT_RETRY 6'h14
`define TTLS_CNT_REELS2 6'h1c
`define TTLS_CNT_BOT_LONG 6'h2c
`define TTLS_CNT_BOT_SHORT 6'h24
`define TTLS_CNT_LEFT_VAC 6'h04
`endif

// >>> rtl/ttls_pkg.sv
package ttls_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    TTLS_IDLE,
    TTLS_THREAD,
    TTLS_RETRY_RW,
    TTLS_WAIT_BOT,
    TTLS_DUMP,
    TTLS_COLS_WAIT,
    TTLS_LOADED,
    TTLS_READY,
    TTLS_ABORT_RW,
    TTLS_STOP
  } ttls_state_e;
endpackage

// >>> rtl/ttls_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ttls_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pin levels
  input wire logic [W-1:0] d_i,
  // Synchronised levels and rising edges
  output logic [W-1:0] q_o,
  output logic [W-1:0] rise_o
);
  logic [W-1:0] meta_reg; // First stage, read only by the second
  logic [W-1:0] q_reg; // Second stage
  logic [W-1:0] prev_reg; // Delayed copy for edge detect

  // Two-stage synchroniser followed by an edge history stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= '0;
      q_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
      prev_reg <= q_reg;
    end
  end

  assign q_o = q_reg;
  assign rise_o = q_reg & ~prev_reg;
endmodule
`default_nettype wire

// >>> rtl/ttls_gap_counter.sv
`timescale 1ns/1ns
`default_nettype none
module ttls_gap_counter #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clr_i,
  input wire logic inc_i,
  // Count
  output logic [W-1:0] count_o
);
  logic [W-1:0] count_reg; // Half-turn count

  // Clear wins over a pulse; saturate so a stalled sequence never wraps into a check
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr_i)
    begin
      count_reg <= '0;
    end
    else if (inc_i && (count_reg != {W{1'b1}}))
    begin
      count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign count_o = count_reg;

  property p_gap_step;
    @(posedge clk_i) disable iff (rst_i)
    (inc_i && !clr_i && (count_reg != {W{1'b1}})) |=> (count_reg == $past(count_reg) + 1'b1);
  endproperty
  a_gap_step: assert property (p_gap_step) else $error("gap count did not advance on pulse");
endmodule
`default_nettype wire

// >>> rtl/ttls_sequencer.sv
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "ttls_map.svh"
// Functional notes
// - Cartridge plus load button sets sequence latch
// - Latch set: window, threading, reels forward
// - Drive opener until cartridge-open switch transfers
// - Gap counter steps per take-up half-turn
// - BOT one-shot clears counter, pulses rewind lines
// - Threading drops at restarted count two
// - Air pressure, not threading: take-up reverses
// - Column port positions raise halts, columns loaded
// - Columns loaded: load complete, manual off
// - Ready only after start after loading
// - First try: tape seen before count seven
// - First try: reels loaded by count twelve
// - Early failure rewinds, counter keeps counting
// - Count twenty retries; reels before twenty-eight
// - Failure at twenty-eight rewinds, aborts, check
// - BOT before 44 or 36, else stop
// - Left lower vacuum four counts after BOT
// - Only the threading phase gets a retry
// - Interlocks inhibit latch and cartridge motor
module ttls_sequencer #(
  parameter int GAP_W = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Operator pushbuttons
  input wire logic load_rewind_pb_i,
  input wire logic start_pb_i,
  input wire logic reset_pb_i,
  // Interlocks
  input wire logic door_open_i,
  input wire logic tape_bottom_i,
  input wire logic safety_bail_i,
  input wire logic mech_ready_i,
  // Tape and cartridge sensors
  input wire logic cartridge_sensed_i,
  input wire logic cartridge_open_sw_i,
  input wire logic radius_pulse_i,
  input wire logic bot_marker_i,
  input wire logic tape_end_sensed_i,
  input wire logic reels_loaded_sw_i,
  input wire logic air_bearing_ok_i,
  input wire logic left_column_second_port_i,
  input wire logic right_column_first_port_i,
  input wire logic left_column_lower_vacuum_switch_i,
  // Actuators
  output logic window_close_o,
  output logic threading_o,
  output logic cartridge_motor_o,
  output logic supply_reel_cw_o,
  output logic takeup_reel_cw_o,
  output logic takeup_reel_ccw_o,
  output logic rewind_file_o,
  // Status lines
  output logic thread_sequence_latch_o,
  output logic load_rewind_o,
  output logic rewind_op_o,
  output logic backward_o,
  output logic halt_left_load_o,
  output logic halt_right_load_o,
  output logic columns_loaded_o,
  output logic load_complete_o,
  output logic manual_status_o,
  output logic ready_o,
  output logic load_check_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  localparam int NIN = 17;
  logic [NIN-1:0] pin_raw; // Raw pin vector
  logic [NIN-1:0] pin_q; // Synchronised levels
  logic [NIN-1:0] pin_rise; // Synchronised rising edges

  assign pin_raw = {load_rewind_pb_i, start_pb_i, reset_pb_i, door_open_i, tape_bottom_i,
                    safety_bail_i, mech_ready_i, cartridge_sensed_i, cartridge_open_sw_i,
                    radius_pulse_i, bot_marker_i, tape_end_sensed_i, reels_loaded_sw_i,
                    air_bearing_ok_i, left_column_second_port_i, right_column_first_port_i,
                    left_column_lower_vacuum_switch_i};

  // Every pin passes two flops before any logic looks at it
  ttls_sync #(.W(NIN)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(pin_raw),
    .q_o(pin_q),
    .rise_o(pin_rise)
  );

  logic load_press; // Load/rewind press edge
  logic start_press; // Start press edge
  logic reset_pb; // Reset pushbutton level
  logic cart_sensed; // Cartridge on supply hub
  logic cart_open; // Cartridge-open switch transferred
  logic gap_pulse; // Half-turn pulse edge
  logic bot_edge; // BOT marker arrives
  logic tape_seen_now; // Tape at tape-end photosensors
  logic reels_ok; // Reels-loaded switch transferred
  logic air_ok; // Air bearing pressure present
  logic below_left_port; // Tape below left second port
  logic below_right_port; // Tape below right first port
  logic left_vac_ok; // Left lower vacuum switch transferred
  logic inhibit; // Any interlock condition

  assign load_press = pin_rise[16];
  assign start_press = pin_rise[15];
  assign reset_pb = pin_q[14];
  assign cart_sensed = pin_q[9];
  assign cart_open = pin_q[8];
  assign gap_pulse = pin_rise[7];
  assign bot_edge = pin_rise[6];
  assign tape_seen_now = pin_q[5];
  assign reels_ok = pin_q[4];
  assign air_ok = pin_q[3];
  assign below_left_port = pin_q[2];
  assign below_right_port = pin_q[1];
  assign left_vac_ok = pin_q[0];
  // Door, tape bottom, reset, bail or lost mechanical ready all block loading
  assign inhibit = pin_q[13] | pin_q[12] | reset_pb | pin_q[11] | ~pin_q[10];

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone registers
  logic ack_reg; // One-cycle acknowledge
  logic [31:0] rdata_reg; // Read data
  logic long_bot_reg; // Longer BOT limit selected
  logic wb_req; // New request this cycle
  logic [31:0] status_word; // Live status

  ttls_pkg::ttls_state_e state_reg; // Sequencer state
  ttls_pkg::ttls_state_e state_next; // Next sequencer state
  logic [GAP_W-1:0] gap_cnt; // Gap counter value
  logic attempt2_reg; // Second threading attempt running
  logic tape_seen_reg; // Tape seen during either threading attempt
  logic load_check_reg; // Load check error indication

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;

  always_comb
  begin
    status_word = 32'h0;
    status_word[`TTLS_ST_STATE] = state_reg;
    status_word[`TTLS_ST_LOAD_CHECK] = load_check_reg;
    status_word[`TTLS_ST_READY] = (state_reg == ttls_pkg::TTLS_READY);
    status_word[`TTLS_ST_ATTEMPT2] = attempt2_reg;
    status_word[`TTLS_ST_TAPE_SEEN] = tape_seen_reg;
    status_word[`TTLS_ST_GAP] = gap_cnt;
  end

  // Answer one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= wb_req;
      if (wb_req && !wb_we_i)
      begin
        case (wb_adr_i)
          `TTLS_REG_CTRL: rdata_reg <= {31'h0, long_bot_reg};
          `TTLS_REG_STATUS: rdata_reg <= status_word;
          default: rdata_reg <= 32'h0;
        endcase
      end
    end
  end

  // Control write; only byte lane 0 holds a field
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      long_bot_reg <= `TTLS_CTRL_RESET;
    end
    else if (wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `TTLS_REG_CTRL))
    begin
      long_bot_reg <= wb_dat_i[`TTLS_CTRL_LONG_BOT];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Gap counter
  logic latch_set; // Sequence latch sets this cycle
  logic gap_clr; // Counter clear
  logic [GAP_W-1:0] gap_plus; // Count the pulse will produce
  logic [GAP_W-1:0] bot_limit; // BOT deadline chosen by the control register

  assign latch_set = (state_reg == ttls_pkg::TTLS_IDLE) && load_press && cart_sensed && !inhibit;
  assign gap_clr = latch_set | ((state_reg == ttls_pkg::TTLS_WAIT_BOT) && bot_edge);
  assign gap_plus = gap_cnt + {{(GAP_W-1){1'b0}}, 1'b1};
  assign bot_limit = long_bot_reg ? `TTLS_CNT_BOT_LONG : `TTLS_CNT_BOT_SHORT;

  ttls_gap_counter #(.W(GAP_W)) u_gap (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(gap_clr),
    .inc_i(gap_pulse),
    .count_o(gap_cnt)
  );

  // A check fires on the pulse that brings the count to its figure
  function automatic logic reach(input logic [GAP_W-1:0] plus, input logic [GAP_W-1:0] n, input logic p);
    reach = p && (plus == n);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ttls_pkg::TTLS_IDLE:
        if (latch_set) state_next = ttls_pkg::TTLS_THREAD;
      ttls_pkg::TTLS_THREAD:
        if (attempt2_reg)
        begin
          if (reels_ok) state_next = ttls_pkg::TTLS_WAIT_BOT;
          else if (reach(gap_plus, `TTLS_CNT_REELS2, gap_pulse)) state_next = ttls_pkg::TTLS_ABORT_RW;
        end
        else if (reels_ok && (tape_seen_reg || tape_seen_now)) state_next = ttls_pkg::TTLS_WAIT_BOT;
        else if (reach(gap_plus, `TTLS_CNT_TAPE, gap_pulse) && !tape_seen_reg && !tape_seen_now)
          state_next = ttls_pkg::TTLS_RETRY_RW;
        else if (reach(gap_plus, `TTLS_CNT_REELS1, gap_pulse)) state_next = ttls_pkg::TTLS_RETRY_RW;
      ttls_pkg::TTLS_RETRY_RW:
        if (reach(gap_plus, `TTLS_CNT_RETRY, gap_pulse)) state_next = ttls_pkg::TTLS_THREAD;
      ttls_pkg::TTLS_WAIT_BOT:
        if (bot_edge) state_next = ttls_pkg::TTLS_DUMP;
        else if (reach(gap_plus, bot_limit, gap_pulse)) state_next = ttls_pkg::TTLS_STOP;
      ttls_pkg::TTLS_DUMP:
        if (reach(gap_plus, `TTLS_CNT_LEFT_VAC, gap_pulse))
          state_next = left_vac_ok ? ttls_pkg::TTLS_COLS_WAIT : ttls_pkg::TTLS_STOP;
      ttls_pkg::TTLS_COLS_WAIT:
        if (below_left_port && below_right_port) state_next = ttls_pkg::TTLS_LOADED;
      ttls_pkg::TTLS_LOADED:
        if (start_press) state_next = ttls_pkg::TTLS_READY;
      ttls_pkg::TTLS_READY:
        state_next = ttls_pkg::TTLS_READY;
      ttls_pkg::TTLS_ABORT_RW:
        // Rewind until the leader clears the tape-end sensors
        if (!tape_seen_now) state_next = ttls_pkg::TTLS_STOP;
      ttls_pkg::TTLS_STOP:
        state_next = ttls_pkg::TTLS_STOP;
      default:
        state_next = ttls_pkg::TTLS_IDLE;
    endcase
    // The reset pushbutton always drops the sequence
    if (reset_pb) state_next = ttls_pkg::TTLS_IDLE;
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i) state_reg <= ttls_pkg::TTLS_IDLE;
    else state_reg <= state_next;
  end

  // Attempt tracking: entering the rewind phase arms the one retry
  always_ff @(posedge clk_i)
  begin
    if (rst_i || latch_set) attempt2_reg <= 1'b0;
    else if (state_reg == ttls_pkg::TTLS_RETRY_RW) attempt2_reg <= 1'b1;
  end

  // Tape presence remembered through the first attempt
  always_ff @(posedge clk_i)
  begin
    if (rst_i || latch_set) tape_seen_reg <= 1'b0;
    else if ((state_reg == ttls_pkg::TTLS_THREAD) && tape_seen_now) tape_seen_reg <= 1'b1;
  end

  // Load check stays lit after an abort until the operator resets or reloads
  always_ff @(posedge clk_i)
  begin
    if (rst_i) load_check_reg <= 1'b0;
    else if (state_next == ttls_pkg::TTLS_ABORT_RW) load_check_reg <= 1'b1;
    else if (reset_pb || latch_set) load_check_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cartridge motor
  logic cart_run_reg; // Opener drive requested

  // Drive stops the moment the open switch transfers
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cart_open || reset_pb) cart_run_reg <= 1'b0;
    else if (latch_set) cart_run_reg <= 1'b1;
  end

  assign cartridge_motor_o = cart_run_reg & ~cart_open & ~inhibit;

  ////////////////////////////////////////////////////////////////////////////
  // BOT one-shot and status lines
  logic bot_shot_reg; // One-cycle BOT pulse

  always_ff @(posedge clk_i)
  begin
    if (rst_i) bot_shot_reg <= 1'b0;
    else bot_shot_reg <= (state_reg == ttls_pkg::TTLS_WAIT_BOT) && bot_edge && !reset_pb;
  end

  logic threading; // Transfer valve energised
  logic seq_active; // Latch held
  logic loading; // Tape travelling during dump or column wait

  assign seq_active = (state_reg != ttls_pkg::TTLS_IDLE) && (state_reg != ttls_pkg::TTLS_STOP);
  // Valve drops on the count of two after BOT
  assign threading = (state_reg == ttls_pkg::TTLS_THREAD) || (state_reg == ttls_pkg::TTLS_WAIT_BOT) ||
                     ((state_reg == ttls_pkg::TTLS_DUMP) && (gap_cnt < `TTLS_CNT_THREAD_OFF));
  assign loading = (state_reg == ttls_pkg::TTLS_DUMP) || (state_reg == ttls_pkg::TTLS_COLS_WAIT);

  assign thread_sequence_latch_o = seq_active;
  assign window_close_o = seq_active;
  assign threading_o = threading;
  assign rewind_file_o = (state_reg == ttls_pkg::TTLS_RETRY_RW) || (state_reg == ttls_pkg::TTLS_ABORT_RW);
  // Reels forward while threading; both stop once normal column control takes over
  assign supply_reel_cw_o = threading || loading;
  assign takeup_reel_cw_o = threading;
  assign takeup_reel_ccw_o = rewind_file_o || (loading && air_ok && !threading);
  assign load_rewind_o = bot_shot_reg;
  assign rewind_op_o = bot_shot_reg;
  assign backward_o = bot_shot_reg;
  // Halts follow the ports from the dump onward, so they stay up beside columns loaded
  assign halt_left_load_o = (loading || columns_loaded_o) && below_left_port && below_right_port;
  assign halt_right_load_o = (loading || columns_loaded_o) && below_left_port && below_right_port;
  assign columns_loaded_o = (state_reg == ttls_pkg::TTLS_LOADED) || (state_reg == ttls_pkg::TTLS_READY);
  assign load_complete_o = columns_loaded_o;
  assign manual_status_o = !columns_loaded_o;
  assign ready_o = (state_reg == ttls_pkg::TTLS_READY);
  assign load_check_o = load_check_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_latch_blocked;
    @(posedge clk_i) disable iff (rst_i)
    ((state_reg == ttls_pkg::TTLS_IDLE) && inhibit) |=> (state_reg == ttls_pkg::TTLS_IDLE);
  endproperty
  a_latch_blocked: assert property (p_latch_blocked) else $error("latch set under interlock");

  property p_latch_sets;
    @(posedge clk_i) disable iff (rst_i)
    latch_set |=> (threading_o && window_close_o && takeup_reel_cw_o && supply_reel_cw_o && gap_cnt == 6'h00);
  endproperty
  a_latch_sets: assert property (p_latch_sets) else $error("thread start outputs wrong");

  property p_cart_off;
    @(posedge clk_i) disable iff (rst_i)
    cart_open |-> !cartridge_motor_o;
  endproperty
  a_cart_off: assert property (p_cart_off) else $error("opener driven after open");

  property p_bot_clear;
    @(posedge clk_i) disable iff (rst_i)
    ((state_reg == ttls_pkg::TTLS_WAIT_BOT) && bot_edge && !reset_pb) |=> (gap_cnt == 6'h00 && load_rewind_o && backward_o);
  endproperty
  a_bot_clear: assert property (p_bot_clear) else $error("BOT one-shot missing");

  property p_thread_drop;
    @(posedge clk_i) disable iff (rst_i)
    ((state_reg == ttls_pkg::TTLS_DUMP) && gap_cnt >= `TTLS_CNT_THREAD_OFF) |-> !threading_o;
  endproperty
  a_thread_drop: assert property (p_thread_drop) else $error("threading held past count two");

  property p_reverse;
    @(posedge clk_i) disable iff (rst_i)
    (loading && air_ok && !threading) |-> (takeup_reel_ccw_o && !takeup_reel_cw_o && supply_reel_cw_o);
  endproperty
  a_reverse: assert property (p_reverse) else $error("take-up did not reverse");

  property p_first_fail;
    @(posedge clk_i) disable iff (rst_i)
    ((state_reg == ttls_pkg::TTLS_THREAD) && !attempt2_reg && !reels_ok && !reset_pb &&
     reach(gap_plus, `TTLS_CNT_REELS1, gap_pulse)) |=> (rewind_file_o ##1 attempt2_reg);
  endproperty
  a_first_fail: assert property (p_first_fail) else $error("no retry after count twelve");

  property p_abort;
    @(posedge clk_i) disable iff (rst_i)
    ((state_reg == ttls_pkg::TTLS_THREAD) && attempt2_reg && !reels_ok && !reset_pb &&
     reach(gap_plus, `TTLS_CNT_REELS2, gap_pulse)) |=> (load_check_o && rewind_file_o);
  endproperty
  a_abort: assert property (p_abort) else $error("second failure not flagged");

  property p_bot_late;
    @(posedge clk_i) disable iff (rst_i)
    ((state_reg == ttls_pkg::TTLS_WAIT_BOT) && !bot_edge && !reset_pb && reach(gap_plus, bot_limit, gap_pulse))
      |=> (state_reg == ttls_pkg::TTLS_STOP && !rewind_file_o);
  endproperty
  a_bot_late: assert property (p_bot_late) else $error("late BOT did not stop");

  property p_ready_start;
    @(posedge clk_i) disable iff (rst_i)
    $rose(ready_o) |-> $past(start_press) && $past(columns_loaded_o);
  endproperty
  a_ready_start: assert property (p_ready_start) else $error("ready without start");

endmodule
`default_nettype wire

// >>> tb/ttls_tape_model.sv
`timescale 1ns/1ns
`default_nettype none
module ttls_tape_model #(
  parameter int HALF = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Motor commands
  input wire logic run_i,
  input wire logic cart_motor_i,
  // Sensor levels
  output logic radius_pulse_o,
  output logic cartridge_open_sw_o
);
  logic [7:0] div_reg; // Half-turn divider
  logic [3:0] open_reg; // Opener travel
  ////////////////////////////////////////
  // Photocell moves only while a reel turns, so a stalled reel gives no counts
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      div_reg <= 8'h00;
      radius_pulse_o <= 1'b0;
    end
    else if (div_reg == 8'(HALF - 1))
    begin
      div_reg <= 8'h00;
      radius_pulse_o <= !radius_pulse_o;
    end
    else
      div_reg <= div_reg + 8'h01;
  end
  // Opener turns while driven; switch transfers at full travel
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      open_reg <= 4'h0;
    else if (cart_motor_i && open_reg != 4'hf)
      open_reg <= open_reg + 4'h1;
  end
  assign cartridge_open_sw_o = (open_reg == 4'hf);
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic load_rewind_pb_i = 1'b0, start_pb_i = 1'b0, reset_pb_i = 1'b0, cartridge_sensed_i = 1'b1;
  logic door_open_i = 1'b0, tape_bottom_i = 1'b0, safety_bail_i = 1'b0, mech_ready_i = 1'b1;
  logic bot_marker_i = 1'b0, tape_end_sensed_i = 1'b0, reels_loaded_sw_i = 1'b0, air_bearing_ok_i = 1'b1;
  logic left_column_second_port_i = 1'b0, right_column_first_port_i = 1'b0;
  logic left_column_lower_vacuum_switch_i = 1'b0, radius_pulse_i, cartridge_open_sw_i;
  logic window_close_o, threading_o, cartridge_motor_o, supply_reel_cw_o, takeup_reel_cw_o;
  logic takeup_reel_ccw_o, rewind_file_o, thread_sequence_latch_o, load_rewind_o, rewind_op_o, backward_o;
  logic halt_left_load_o, halt_right_load_o, columns_loaded_o, load_complete_o, manual_status_o;
  logic ready_o, load_check_o;
  int errors = 0, check_count = 0, cycles = 0;
  ttls_sequencer i_dut (.*);
  // Far side turns reels and opens the cartridge
  ttls_tape_model i_tape (.clk_i(clk_i), .rst_i(rst_i), .run_i(supply_reel_cw_o | takeup_reel_ccw_o),
    .cart_motor_i(cartridge_motor_o), .radius_pulse_o(radius_pulse_i), .cartridge_open_sw_o(cartridge_open_sw_i));
  always #25 clk_i = !clk_i;
  ////////////////////////////////////////
  // Verdict and counts
  task conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard; whole run needs under two thousand cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      errors++;
      conclude;
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // Classic cycle held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task gap(input logic [5:0] e);
    wb(1'b0, 8'h04, 32'h0);
    chk(q[13:8], e);
  endtask
  // Buttons held well past the two-clock pin latency
  task press(input logic s);
    if (s)
      start_pb_i <= 1'b1;
    else
      load_rewind_pb_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    start_pb_i <= 1'b0;
    load_rewind_pb_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  task rpb;
    {tape_end_sensed_i, reels_loaded_sw_i, left_column_lower_vacuum_switch_i} <= 3'h0;
    {left_column_second_port_i, right_column_first_port_i, reset_pb_i} <= 3'h1;
    repeat (6) @(posedge clk_i);
    reset_pb_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  ////////////////////////////////////////
  task t_regs;
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, 8'h04, 32'hffffffff);
    wb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    chk(manual_status_o, 1'b1);
  endtask
  // Door, tape bottom, bail and lost ready each alone block the load press
  task t_inhibit;
    for (int i = 0; i < 4; i++)
    begin
      {door_open_i, tape_bottom_i, safety_bail_i, mech_ready_i} <= (4'h8 >> i) ^ 4'h1;
      press(1'b0);
      chk({thread_sequence_latch_o, cartridge_motor_o}, 2'h0);
    end
    {door_open_i, tape_bottom_i, safety_bail_i, mech_ready_i} <= 4'h1;
  endtask
  task t_load;
    tape_end_sensed_i <= 1'b1;
    press(1'b0);
    chk({thread_sequence_latch_o, cartridge_motor_o}, 2'h3);
    chk({window_close_o, threading_o, supply_reel_cw_o, takeup_reel_cw_o}, 4'hf);
    @(posedge clk_i iff cartridge_motor_o === 1'b0);
    chk(cartridge_open_sw_i, 1'b1);
    reels_loaded_sw_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    bot_marker_i <= 1'b1;
    @(posedge clk_i iff load_rewind_o === 1'b1);
    chk({rewind_op_o, backward_o}, 2'h3);
    @(posedge clk_i);
    chk(load_rewind_o, 1'b0);
    gap(6'h00);
    @(posedge clk_i iff threading_o === 1'b0);
    gap(6'h02);
    chk({takeup_reel_ccw_o, supply_reel_cw_o, takeup_reel_cw_o}, 3'h6);
    {left_column_lower_vacuum_switch_i, left_column_second_port_i, right_column_first_port_i} <= 3'h7;
    @(posedge clk_i iff columns_loaded_o === 1'b1);
    gap(6'h04);
    chk({halt_left_load_o, halt_right_load_o, load_complete_o, manual_status_o, ready_o}, 5'h1c);
    press(1'b1);
    chk(ready_o, 1'b1);
    rpb;
  endtask
  // No tape: fail at 7, retry at 20, abort at 28
  task t_retry;
    press(1'b0);
    gap(6'h00);
    @(posedge clk_i iff rewind_file_o === 1'b1);
    gap(6'h07);
    chk(takeup_reel_ccw_o, 1'b1);
    @(posedge clk_i iff threading_o === 1'b1);
    wb(1'b0, 8'h04, 32'h0);
    chk(q[13:0], {6'h14, 8'h41});
    tape_end_sensed_i <= 1'b1;
    @(posedge clk_i iff rewind_file_o === 1'b1);
    wb(1'b0, 8'h04, 32'h0);
    chk({q[13:8], q[4:0]}, {6'h1c, 5'h18});
    tape_end_sensed_i <= 1'b0;
    @(posedge clk_i iff thread_sequence_latch_o === 1'b0);
    chk({load_check_o, rewind_file_o}, 2'h2);
    rpb;
  endtask
  // Tape seen but reels never load: first try fails at count 12
  task t_reels12;
    tape_end_sensed_i <= 1'b1;
    press(1'b0);
    @(posedge clk_i iff rewind_file_o === 1'b1);
    wb(1'b0, 8'h04, 32'h0);
    chk({q[13:8], q[7:0]}, {6'h0c, 8'hc2});
    rpb;
  endtask
  // Short BOT limit, marker never seen
  task t_botlim;
    wb(1'b1, 8'h00, 32'h0);
    tape_end_sensed_i <= 1'b1;
    press(1'b0);
    reels_loaded_sw_i <= 1'b1;
    @(posedge clk_i iff thread_sequence_latch_o === 1'b0);
    wb(1'b0, 8'h04, 32'h0);
    chk({q[13:8], q[3:0]}, {6'h24, 4'h9});
    chk({rewind_file_o, load_check_o, columns_loaded_o}, 3'h0);
    repeat (200) @(posedge clk_i);
    chk(thread_sequence_latch_o, 1'b0);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_inhibit;
    t_load;
    t_retry;
    t_reels12;
    t_botlim;
    conclude;
  end
endmodule
`default_nettype wire
